// >>> inc/stc_consts.svh
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses on the bus).
`define STC_ADR_CTRL   4'h0
`define STC_ADR_LOW    4'h4
`define STC_ADR_HIGH   4'h8
`define STC_ADR_STAT   4'hc

// ==========================================================================
// Control register fields.
`define STC_CTRL_ON     0
`define STC_CTRL_CSS    1
`define STC_CTRL_SYNCD  2
`define STC_CTRL_OSCEN  3
`define STC_CTRL_PS_LO  4
`define STC_CTRL_PS_HI  5
`define STC_CTRL_SYSCLK 6
`define STC_CTRL_WIDE   7

// ==========================================================================
// Status register fields.
`define STC_STAT_OVF    0

// ==========================================================================
// Reset values and counts.
`define STC_CTRL_RST    8'h00
`define STC_COUNT_RST   16'h0000
`define STC_COUNT_MAX   16'hffff
`define STC_INSTR_DIV   4
`define STC_DIV_LAST    2'h3

`endif

// >>> inc/stc_pkg.sv
package stc_pkg;

    // ======================================================================
    // Operating modes, Gray coded along timer, sync counter, async counter.
    typedef enum logic [1:0] {
        STC_TIMER     = 2'h0,
        STC_SYNC_CNT  = 2'h1,
        STC_ASYNC_CNT = 2'h3
    } stc_mode_type;

    function automatic stc_mode_type stc_mode_of(input logic css,
                                                 input logic sync_dis);
        if (!css) begin
            return STC_TIMER;
        end else if (sync_dis) begin
            return STC_ASYNC_CNT;
        end else begin
            return STC_SYNC_CNT;
        end
    endfunction

endpackage

// >>> logic/stc_prescale.sv
`timescale 1ns/1ps

module stc_prescale #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Input edges, clear and ratio.
    input  wire logic       tick_i,
    input  wire logic       clear_i,
    input  wire logic [1:0] sel_i,
    // One pulse per completed ratio.
    output logic            carry_o
);

    logic [WIDTH-1:0] cnt;

    function automatic logic [WIDTH-1:0] ratio_mask(input logic [1:0] s);
        case (s)
            2'h0:    ratio_mask = WIDTH'(0);
            2'h1:    ratio_mask = WIDTH'(1);
            2'h2:    ratio_mask = WIDTH'(3);
            default: ratio_mask = WIDTH'(7);
        endcase
    endfunction

    // ======================================================================
    // Ratio counter.
    // A count left above a smaller new ratio carries at once, not after wrap.
    assign carry_o = tick_i & ~clear_i & (cnt >= ratio_mask(sel_i)); // [R04]

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt <= '0; // [R16]
        end else if (tick_i) begin
            cnt <= carry_o ? '0 : WIDTH'(cnt + WIDTH'(1)); // [R21]
        end
    end

    // ======================================================================
    // Checks.
    property p_clear_zero;
        @(posedge clk_i) disable iff (rst_i)
        clear_i |=> (cnt == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) // [R16]
        else $error("Prescaler not cleared.");

    property p_half_ratio;
        @(posedge clk_i) disable iff (rst_i)
        (carry_o && sel_i == 2'h1 && !clear_i) |=> !carry_o;
    endproperty
    a_half_ratio: assert property (p_half_ratio) // [R04]
        else $error("Ratio 1:2 carried twice in a row.");

endmodule

// >>> logic/stc_sync.sv
`timescale 1ns/1ps

module stc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // ======================================================================
    // Two flops; only the second stage is visible to the block.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// >>> logic/stc_timer.sv
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "stc_consts.svh"

// Summary of operation
// R01 - Timer, synchronous counter and asynchronous counter modes from two bits.
// R02 - Internal source advances once per instruction cycle, clock over four.
// R03 - External source advances on rising edges of the external clock input.
// R04 - Prescale select 00,01,10,11 divides by 1,2,4,8.
// R05 - Sync disable picks raw or synchronised input; ignored with internal clock.
// R06 - Clearing oscillator enable turns its amplifier and feedback off.
// R07 - With oscillator enabled, pin direction is ignored and pins read zero.
// R08 - Read-only status bit shows system clock taken from timer oscillator.
// R09 - Wide access enable makes counter access one 16-bit operation.
// R10 - Wide access cleared gives two independent byte accesses.
// R11 - Wide mode: high address is a buffer, low read copies high byte.
// R12 - Wide mode: writing the high buffer leaves the counter unchanged.
// R13 - Wide mode: low write loads high byte from buffer together.
// R14 - Wide mode: true high byte only reached through the buffer.
// R15 - Writing the high byte leaves the prescaler count alone.
// R16 - Writing the low byte clears the prescaler count.
// R17 - Counter runs while on bit set, holds while cleared.
// R18 - Count wraps ffff to 0000 and latches the overflow flag.
// R19 - Compare-unit special event trigger resets the counter to zero.
// R20 - A software write wins over a simultaneous special event reset.
// R21 - Prescaler counts selected edges, pulses at the ratio, then restarts.
// R22 - Asynchronous counter keeps counting while the instruction clock sleeps.
module stc_timer (
    // Clock and reset.
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave.
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Clock sources and system events.
    input  wire logic                ext_clock_pin_i,
    input  wire logic                sleep_i,
    input  wire logic                special_event_i,
    input  wire logic                sysclk_from_timer_osc_i,
    // Oscillator pins as port pins.
    input  wire logic [1:0]          port_direction_i,
    input  wire logic [1:0]          port_pins_i,
    output logic      [1:0]          port_oe_o,
    output logic      [1:0]          port_read_o,
    output logic                     osc_amp_enable_o,
    // Status.
    output logic                     overflow_flag_o,
    output logic      [15:0]         count_o,
    output stc_pkg::stc_mode_type    mode_o
);

    import stc_pkg::*;

    // ======================================================================
    // Declarations.
    logic         wide_access_enable;
    logic [1:0]   prescale_select;
    logic         timer_osc_enable;
    logic         ext_sync_disable;
    logic         clock_source_select;
    logic         counter_on;
    logic [15:0]  count;
    logic [7:0]   count_high_buffer;
    logic         overflow_flag;
    logic [1:0]   div_cnt;
    logic         ext_prev;
    logic         sync_edge;
    logic [2:0]   pins_s;
    logic         ext_s;
    logic         req;
    logic         wr;
    logic         rd_take;
    logic         hit_ctrl;
    logic         hit_low;
    logic         hit_high;
    logic         hit_stat;
    logic [7:0]   next_rd;
    logic         instr_tick;
    logic         rise;
    logic         src_tick;
    logic         inc;
    logic         wr_low;
    logic         wr_high;
    stc_mode_type mode;

    // ======================================================================
    // Pin synchronisation.
    stc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({port_pins_i, ext_clock_pin_i}),
        .sync_o  (pins_s)
    );

    assign ext_s = pins_s[0];

    // ======================================================================
    // Bus decode.
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr      = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign rd_take = req & ~wb_we_i & ~wb_ack_o;

    always_comb begin
        hit_ctrl = 1'b0;
        hit_low  = 1'b0;
        hit_high = 1'b0;
        hit_stat = 1'b0;
        if (wb_adr_i == `STC_ADR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (wb_adr_i == `STC_ADR_LOW) begin
            hit_low = 1'b1;
        end else if (wb_adr_i == `STC_ADR_HIGH) begin
            hit_high = 1'b1;
        end else if (wb_adr_i == `STC_ADR_STAT) begin
            hit_stat = 1'b1;
        end
    end

    assign wr_low  = wr & hit_low;
    assign wr_high = wr & hit_high;

    always_comb begin
        next_rd = 8'h00;
        if (hit_ctrl) begin
            next_rd = {wide_access_enable, sysclk_from_timer_osc_i, // [R08]
                       prescale_select, timer_osc_enable,
                       ext_sync_disable, clock_source_select,
                       counter_on};
        end else if (hit_low) begin
            next_rd = count[7:0];
        end else if (hit_high) begin
            next_rd = wide_access_enable ? count_high_buffer // [R14]
                                         : count[15:8];      // [R10]
        end else if (hit_stat) begin
            next_rd = {7'h00, overflow_flag};
        end
    end

    // Read data is captured in the first cycle so that a low read and its
    // high-byte copy see the same count value.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (rd_take) begin
                wb_dat_o <= {24'h00_0000, next_rd};
            end
        end
    end

    // ======================================================================
    // Control register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {wide_access_enable, prescale_select, timer_osc_enable,
             ext_sync_disable, clock_source_select, counter_on} <= 7'h00;
        end else if (wr && hit_ctrl) begin
            wide_access_enable  <= wb_dat_i[`STC_CTRL_WIDE];
            prescale_select     <= wb_dat_i[`STC_CTRL_PS_HI:`STC_CTRL_PS_LO];
            timer_osc_enable    <= wb_dat_i[`STC_CTRL_OSCEN];
            ext_sync_disable    <= wb_dat_i[`STC_CTRL_SYNCD];
            clock_source_select <= wb_dat_i[`STC_CTRL_CSS];
            counter_on          <= wb_dat_i[`STC_CTRL_ON];
        end
    end

    assign mode   = stc_mode_of(clock_source_select, ext_sync_disable); // [R01]
    assign mode_o = mode;

    // ======================================================================
    // Oscillator pins.
    assign osc_amp_enable_o = timer_osc_enable; // [R06]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_oe_o   <= 2'h0;
            port_read_o <= 2'h0;
        end else begin
            port_oe_o   <= timer_osc_enable ? 2'h0 : ~port_direction_i; // [R07]
            port_read_o <= timer_osc_enable ? 2'h0 : pins_s[2:1];       // [R07]
        end
    end

    // ======================================================================
    // Clock source selection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt   <= 2'h0;
            ext_prev  <= 1'b0;
            sync_edge <= 1'b0;
        end else begin
            div_cnt   <= 2'(div_cnt + 2'h1);
            ext_prev  <= ext_s;
            sync_edge <= rise & ~sleep_i; // [R05]
        end
    end

    assign instr_tick = (div_cnt == `STC_DIV_LAST); // [R02]
    assign rise       = ext_s & ~ext_prev;          // [R03]

    // The synchronised path needs the instruction clock, so it stops in
    // sleep; the raw path does not, which is what lets it wake the part.
    always_comb begin
        case (mode)
            STC_TIMER:     src_tick = instr_tick & ~sleep_i; // [R02]
            STC_SYNC_CNT:  src_tick = sync_edge;             // [R05]
            STC_ASYNC_CNT: src_tick = rise;                  // [R22]
            default:       src_tick = 1'b0;
        endcase
    end

    stc_prescale #(
        .WIDTH (3)
    ) u_prescale (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (src_tick & counter_on), // [R17]
        .clear_i (wr_low),                // [R16] [R15]
        .sel_i   (prescale_select),
        .carry_o (inc)
    );

    // ======================================================================
    // Counter and high-byte buffer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `STC_COUNT_RST;
        end else if (wr_low) begin
            if (wide_access_enable) begin
                count <= {count_high_buffer, wb_dat_i[7:0]}; // [R13] [R09]
            end else begin
                count[7:0] <= wb_dat_i[7:0]; // [R10] [R20]
            end
        end else if (wr_high && !wide_access_enable) begin
            count[15:8] <= wb_dat_i[7:0]; // [R10] [R20]
        end else if (special_event_i) begin
            count <= `STC_COUNT_RST; // [R19]
        end else if (inc) begin
            count <= 16'(count + 16'h0001); // [R18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_high_buffer <= 8'h00;
        end else if (wr_high) begin
            count_high_buffer <= wb_dat_i[7:0]; // [R12]
        end else if (rd_take && hit_low && wide_access_enable) begin
            count_high_buffer <= count[15:8]; // [R11]
        end
    end

    // A new overflow wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (inc && count == `STC_COUNT_MAX && !wr_low &&
                     !(wr_high && !wide_access_enable) &&
                     !special_event_i) begin
            overflow_flag <= 1'b1; // [R18]
        end else if (wr && hit_stat && wb_dat_i[`STC_STAT_OVF]) begin
            overflow_flag <= 1'b0;
        end
    end

    assign overflow_flag_o = overflow_flag;
    assign count_o         = count;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_instr_gap;
        !instr_tick [*3] ##1 instr_tick;
    endsequence

    property p_instr_rate;
        instr_tick |=> s_instr_gap;
    endproperty
    a_instr_rate: assert property (p_instr_rate) // [R02]
        else $error("Instruction tick not every fourth cycle.");

    property p_rollover;
        (inc && count == 16'hffff && !wr && !special_event_i)
            |=> (count == 16'h0000) && overflow_flag;
    endproperty
    a_rollover: assert property (p_rollover) // [R18]
        else $error("Rollover did not wrap or set the flag.");

    property p_wide_low_write;
        (wr_low && wide_access_enable)
            |=> count == {$past(count_high_buffer), $past(wb_dat_i[7:0])};
    endproperty
    a_wide_low_write: assert property (p_wide_low_write) // [R13]
        else $error("Wide low write did not load all sixteen bits.");

    property p_wide_high_hold;
        (wr_high && wide_access_enable && !inc && !special_event_i)
            |=> $stable(count);
    endproperty
    a_wide_high_hold: assert property (p_wide_high_hold) // [R12]
        else $error("Buffer write changed the counter.");

    property p_low_read_copy;
        (rd_take && hit_low && wide_access_enable && !wr_high)
            |=> count_high_buffer == $past(count[15:8]);
    endproperty
    a_low_read_copy: assert property (p_low_read_copy) // [R11]
        else $error("Low read did not copy the high byte.");

    property p_write_beats_event;
        (wr_low && special_event_i && !wide_access_enable)
            |=> count[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_write_beats_event: assert property (p_write_beats_event) // [R20]
        else $error("Special event reset overrode a write.");

    property p_event_reset;
        (special_event_i && !wr_low && !wr_high) |=> count == 16'h0000;
    endproperty
    a_event_reset: assert property (p_event_reset) // [R19]
        else $error("Special event did not clear the counter.");

    property p_off_hold;
        (!counter_on && !wr_low && !wr_high && !special_event_i)
            |=> $stable(count);
    endproperty
    a_off_hold: assert property (p_off_hold) // [R17]
        else $error("Counter moved while switched off.");

    property p_sync_sleep;
        (mode == STC_SYNC_CNT && $past(sleep_i)) |-> !src_tick;
    endproperty
    a_sync_sleep: assert property (p_sync_sleep) // [R05]
        else $error("Synchronised input counted during sleep.");

    property p_async_sleep;
        (mode == STC_ASYNC_CNT && rise) |-> src_tick;
    endproperty
    a_async_sleep: assert property (p_async_sleep) // [R22]
        else $error("Raw input edge dropped.");

    property p_osc_pins;
        timer_osc_enable |=> port_read_o == 2'h0 && port_oe_o == 2'h0;
    endproperty
    a_osc_pins: assert property (p_osc_pins) // [R07]
        else $error("Oscillator pins not released.");

endmodule

// >>> tb/stc_testbench.sv
`timescale 1ns/1ps
`include "stc_consts.svh"

module testbench;
    import stc_pkg::*;

    // ======================================================================
    // Signals.
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ext_clock_pin_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic        special_event_i = 1'b0;
    logic        sysclk_from_timer_osc_i = 1'b0;
    logic [1:0]  port_direction_i = 2'h0;
    logic [1:0]  port_pins_i = 2'h2;
    logic [1:0]  port_oe_o;
    logic [1:0]  port_read_o;
    logic        osc_amp_enable_o;
    logic        overflow_flag_o;
    logic [15:0] count_o;
    stc_mode_type mode_o;
    int          fails = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic [15:0] c0;

    stc_timer dut (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .wb_cyc_i                (wb_cyc_i),
        .wb_stb_i                (wb_stb_i),
        .wb_we_i                 (wb_we_i),
        .wb_adr_i                (wb_adr_i),
        .wb_sel_i                (wb_sel_i),
        .wb_dat_i                (wb_dat_i),
        .wb_dat_o                (wb_dat_o),
        .wb_ack_o                (wb_ack_o),
        .ext_clock_pin_i         (ext_clock_pin_i),
        .sleep_i                 (sleep_i),
        .special_event_i         (special_event_i),
        .sysclk_from_timer_osc_i (sysclk_from_timer_osc_i),
        .port_direction_i        (port_direction_i),
        .port_pins_i             (port_pins_i),
        .port_oe_o               (port_oe_o),
        .port_read_o             (port_read_o),
        .osc_amp_enable_o        (osc_amp_enable_o),
        .overflow_flag_o         (overflow_flag_o),
        .count_o                 (count_o),
        .mode_o                  (mode_o)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ======================================================================
    // Bus cycles. The request is held until ack is sampled high.
    task automatic wb_cycle(input logic we, input logic [3:0] adr,
                            input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        // One more edge so that callers see what the write has changed.
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, adr, d, q);
    endtask

    task automatic rdr(input logic [3:0] adr, output logic [31:0] q);
        wb_cycle(1'b0, adr, 8'h00, q);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, fails);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_reset_regs();
        rdr(`STC_ADR_CTRL, rd);
        check(rd, 32'h0);
        check({30'h0, mode_o}, {30'h0, STC_TIMER});
        sysclk_from_timer_osc_i <= 1'b1;
        wr(`STC_ADR_CTRL, 8'h00);
        rdr(`STC_ADR_CTRL, rd);
        check(rd, 32'h40);
        sysclk_from_timer_osc_i <= 1'b0;
        wr(`STC_ADR_CTRL, 8'h40);
        rdr(`STC_ADR_CTRL, rd);
        check(rd, 32'h0);
        rdr(4'h2, rd);
        check(rd, 32'h0);
        done("reset");
    endtask

    // Ticks are periodic, so a window of eight periods holds eight ticks.
    task automatic t_timer_ratio();
        for (int ps = 0; ps < 4; ps++) begin
            wr(`STC_ADR_CTRL, {2'h0, ps[1:0], 4'h1});
            wait_n(40);
            c0 = count_o;
            wait_n(4 * (1 << ps) * 8);
            check(count_o - c0, 32'h8);
        end
        wr(`STC_ADR_CTRL, 8'h00);
        c0 = count_o;
        wait_n(80);
        check(count_o, c0);
        done("timer_ratio");
    endtask

    task automatic ext_edges(input int n);
        repeat (n) begin
            ext_clock_pin_i <= 1'b1;
            wait_n(3);
            ext_clock_pin_i <= 1'b0;
            wait_n(3);
        end
        wait_n(8);
    endtask

    task automatic t_external();
        wr(`STC_ADR_CTRL, 8'h03);
        wait_n(8);
        check({30'h0, mode_o}, {30'h0, STC_SYNC_CNT});
        c0 = count_o;
        ext_edges(8);
        check(count_o - c0, 32'h8);
        sleep_i <= 1'b1;
        c0 = count_o;
        ext_edges(5);
        check(count_o, c0);
        wr(`STC_ADR_CTRL, 8'h07);
        wait_n(8);
        check({30'h0, mode_o}, {30'h0, STC_ASYNC_CNT});
        c0 = count_o;
        ext_edges(6);
        check(count_o - c0, 32'h6);
        sleep_i <= 1'b0;
        wr(`STC_ADR_CTRL, 8'h27);
        c0 = count_o;
        ext_edges(8);
        check(count_o - c0, 32'h2);
        wr(`STC_ADR_CTRL, 8'h00);
        done("external");
    endtask

    task automatic t_wide();
        wr(`STC_ADR_CTRL, 8'h80);
        wr(`STC_ADR_LOW, 8'h00);
        c0 = count_o;
        wr(`STC_ADR_HIGH, 8'h12);
        check(count_o, c0);
        wr(`STC_ADR_LOW, 8'h34);
        check(count_o, 32'h1234);
        wr(`STC_ADR_HIGH, 8'hab);
        wr(`STC_ADR_LOW, 8'hcd);
        wr(`STC_ADR_HIGH, 8'h00);
        rdr(`STC_ADR_LOW, rd);
        check(rd, 32'hcd);
        rdr(`STC_ADR_HIGH, rd);
        check(rd, 32'hab);
        wr(`STC_ADR_CTRL, 8'h00);
        wr(`STC_ADR_HIGH, 8'h56);
        check(count_o, 32'h56cd);
        wr(`STC_ADR_LOW, 8'h78);
        rdr(`STC_ADR_HIGH, rd);
        check(rd, 32'h56);
        check(count_o, 32'h5678);
        done("wide");
    endtask

    // Writes spaced well under one prescaled period of 32 clocks.
    task automatic t_prescale_clear();
        wr(`STC_ADR_HIGH, 8'h00);
        wr(`STC_ADR_LOW, 8'h10);
        wr(`STC_ADR_CTRL, 8'h31);
        repeat (20) begin
            wr(`STC_ADR_LOW, 8'h10);
            wait_n(4);
        end
        check(count_o, 32'h0010);
        repeat (20) begin
            wr(`STC_ADR_HIGH, 8'h00);
            wait_n(4);
        end
        check(count_o[7:0] != 8'h10, 32'h1);
        wr(`STC_ADR_CTRL, 8'h00);
        done("prescale_clear");
    endtask

    task automatic t_overflow();
        wr(`STC_ADR_HIGH, 8'hff);
        wr(`STC_ADR_LOW, 8'hfe);
        check(overflow_flag_o, 32'h0);
        wr(`STC_ADR_CTRL, 8'h01);
        wait_n(24);
        wr(`STC_ADR_CTRL, 8'h00);
        check(count_o[15:8], 32'h0);
        check(overflow_flag_o, 32'h1);
        rdr(`STC_ADR_STAT, rd);
        check(rd, 32'h1);
        wr(`STC_ADR_STAT, 8'h01);
        rdr(`STC_ADR_STAT, rd);
        check(rd, 32'h0);
        done("overflow");
    endtask

    task automatic t_special();
        wr(`STC_ADR_HIGH, 8'h05);
        wr(`STC_ADR_LOW, 8'h05);
        special_event_i <= 1'b1;
        wait_n(1);
        special_event_i <= 1'b0;
        wait_n(2);
        check(count_o, 32'h0);
        check(overflow_flag_o, 32'h0);
        wr(`STC_ADR_HIGH, 8'h05);
        fork
            wr(`STC_ADR_LOW, 8'h77);
            begin
                wait_n(2);
                special_event_i <= 1'b1;
                wait_n(1);
                special_event_i <= 1'b0;
            end
        join
        wait_n(1);
        check(count_o, 32'h0577);
        done("special");
    endtask

    task automatic t_osc_pins();
        port_direction_i <= 2'h1;
        port_pins_i <= 2'h3;
        wr(`STC_ADR_CTRL, 8'h08);
        wait_n(5);
        check(osc_amp_enable_o, 32'h1);
        check(port_oe_o, 32'h0);
        check(port_read_o, 32'h0);
        wr(`STC_ADR_CTRL, 8'h00);
        wait_n(5);
        check(osc_amp_enable_o, 32'h0);
        check(port_oe_o, 32'h2);
        check(port_read_o, 32'h3);
        done("osc_pins");
    endtask

    // ======================================================================
    // Verdict.
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        fails++;
        report_and_stop();
    end

    initial begin
        wait_n(4);
        rst_i <= 1'b0;
        t_reset_regs();
        t_timer_ratio();
        t_external();
        t_wide();
        t_prescale_clear();
        t_overflow();
        t_special();
        t_osc_pins();
        report_and_stop();
    end

endmodule
